// [src/fsk_irq_defines.svh]
// Constants for the status-flag and pin-routing block and its host end.
// Assumes inclusion by bare name from every file that needs them.
`ifndef FSK_IRQ_DEFINES_SVH
`define FSK_IRQ_DEFINES_SVH
// Device register offsets on the register link.
`define FSK_ADDR_W 7
`define FSK_OFS_FLAGS_ONE 7'h3E
`define FSK_OFS_FLAGS_TWO 7'h3F
`define FSK_OFS_ROUTE_LOW 7'h40
`define FSK_OFS_ROUTE_HIGH 7'h41
`define FSK_ROUTE_RESET 8'h00
`define FSK_ROUTE_HIGH_RSVD 8'h0E
`define FSK_ROUTE_HIGH_PRE 0
// Bit positions in status_flags_one.
`define FSK_B1_SETTLED 7
`define FSK_B1_RX 6
`define FSK_B1_TX 5
`define FSK_B1_LOCK 4
`define FSK_B1_RSSI 3
`define FSK_B1_TIMEOUT 2
`define FSK_B1_PRE 1
`define FSK_B1_SYNC 0
// Bit positions in status_flags_two.
`define FSK_B2_FULL 7
`define FSK_B2_VACANT 6
`define FSK_B2_LEVEL 5
`define FSK_B2_OVF 4
`define FSK_B2_SENT 3
`define FSK_B2_RECV 2
`define FSK_B2_CRC 1
`define FSK_B2_LOW 0
// Data queue.
`define FSK_FIFO_DEPTH 66
`define FSK_CNT_W 7
// Pin routing tables: 24 five-bit source indices, pin 0 code 0 in the top slot.
// Index 15..8 is status_flags_one, 7..0 status_flags_two, 16 is constant low.
`define FSK_MAP_PACKET {5'h02, 5'h01, 5'h10, 5'h10, 5'h05, 5'h06, 5'h07, 5'h10, \
   5'h07, 5'h10, 5'h10, 5'h10, 5'h06, 5'h0D, 5'h01, 5'h10, \
   5'h10, 5'h0C, 5'h0A, 5'h0B, 5'h10, 5'h0C, 5'h0F, 5'h10}
`define FSK_MAP_CONT {5'h08, 5'h0B, 5'h10, 5'h10, 5'h0C, 5'h10, 5'h10, 5'h10, \
   5'h10, 5'h10, 5'h10, 5'h10, 5'h0A, 5'h0B, 5'h10, 5'h0D, \
   5'h10, 5'h0C, 5'h0A, 5'h0B, 5'h10, 5'h0C, 5'h0E, 5'h0F}
`define FSK_SRC_ZERO 5'h10
// Host APB register map.
`define FSK_APB_CMD 8'h00
`define FSK_APB_STATUS 8'h04
`define FSK_APB_PINS 8'h08
`define FSK_CMD_WRITE 16
`endif

// [src/fsk_pkg.sv]
// Types shared by the device end and the host end.
// Assumes nothing beyond a SystemVerilog compiler.
package fsk_pkg;
   typedef enum logic [2:0] {fsk_sleep, fsk_standby, fsk_fs, fsk_rx, fsk_tx} fsk_op_type;
   typedef enum logic [1:0] {fsk_packet, fsk_continuous, fsk_long_range} fsk_data_type;
endpackage

// [src/fsk_if.sv]
// Register link and event pins between the device and its host.
// Assumes both ends run on the same pclk.
`timescale 1ns/10ps
`default_nettype none
interface fsk_if;
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic reg_ack;
   logic [5:0] event_pin;
   modport dev (input reg_addr, reg_wdata, reg_wr, reg_rd,
      output reg_rdata, reg_ack, event_pin);
   modport host (output reg_addr, reg_wdata, reg_wr, reg_rd,
      input reg_rdata, reg_ack, event_pin);
endinterface
`default_nettype wire

// [src/fsk_irq_dev.sv]
// Device end: status flags, data queue fill state and event pin routing.
// Assumes modem events arrive on pclk; only the supply comparator is asynchronous.
// Summary of operation
// - Mode settled on target state, cleared on change
// - Receive settled after chain done, drops leaving
// - Transmit settled after ramp, drops leaving transmit
// - Lock flag follows synthesizer in FS/RX/TX
// - Strength flag sets above limit, clears leaving/W1C
// - Timeout read-only, cleared leaving receive or emptying
// - Preamble flag sets on detect, W1C only
// - Sync flag; W1C only in continuous mode
// - Full flag while queue holds sixty-six bytes
// - Vacant flag while queue holds no bytes
// - Level flag when count exceeds threshold strictly
// - Overflow flag; writing one flushes the queue
// - Frame sent in transmit, cleared leaving transmit
// - Frame received after last byte, CRC gated
// - Check passed on good CRC, cleared emptying
// - Supply low latches until host writes one
// - Low route register: four selectors, reset zero
// - High route register: pins four, five
// - Selector meaning depends on data mode
// - High bit zero picks strength or preamble
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "fsk_irq_defines.svh"
module fsk_irq_dev
   import fsk_pkg::*;
#(
   parameter int FIFO_DEPTH = `FSK_FIFO_DEPTH
) (
   input wire logic pclk,
   input wire logic presetn,
   fsk_if.dev link,
   input wire fsk_op_type op_mode,
   input wire fsk_data_type data_mode,
   input wire logic osc_running,
   input wire logic synth_lock_in,
   input wire logic rssi_sampling,
   input wire logic rx_chain_done,
   input wire logic pa_ramp_done,
   input wire logic [7:0] signal_strength_value,
   input wire logic [7:0] signal_strength_limit,
   input wire logic timeout_evt,
   input wire logic preamble_evt,
   input wire logic sync_evt,
   input wire logic fifo_push,
   input wire logic fifo_pop,
   input wire logic [6:0] queue_threshold,
   input wire logic packet_done_evt,
   input wire logic last_byte_evt,
   input wire logic crc_ok_evt,
   input wire logic crc_on,
   input wire logic check_fail_keep,
   input wire logic supply_below,
   output logic fifo_flush,
   output logic [6:0] fifo_count
);
   localparam logic [`FSK_CNT_W-1:0] DEPTH = `FSK_CNT_W'(FIFO_DEPTH);
   localparam logic [119:0] MAP_PACKET = `FSK_MAP_PACKET;
   localparam logic [119:0] MAP_CONT = `FSK_MAP_CONT;

   // Source index for one pin and code; long-range events live elsewhere.
   function automatic logic [4:0] pin_src(input logic [2:0] pin, input logic [1:0] code,
      input fsk_data_type dm);
      logic [4:0] slot;
      slot = 5'(pin) * 5'h04 + 5'(code);
      unique case (dm)
         fsk_packet: pin_src = MAP_PACKET[7'(5'h17 - slot) * 7'h05 +: 5];
         fsk_continuous: pin_src = MAP_CONT[7'(5'h17 - slot) * 7'h05 +: 5];
         fsk_long_range: pin_src = `FSK_SRC_ZERO;
         default: pin_src = `FSK_SRC_ZERO;
      endcase
   endfunction

   fsk_op_type mode_prev_r;
   logic [7:0] flags_one_r, flags_one_nxt;
   logic [4:0] flags_two_r, flags_two_nxt;
   logic [7:0] route_low_r, route_high_r;
   logic [`FSK_CNT_W-1:0] count_r, count_nxt;
   logic supply_meta_r, supply_sync_r;
   logic [7:0] rdata_r;
   logic ack_r, flush_r;
   logic [5:0] pin_r, pin_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode of mode, register writes and queue state.
   wire mode_chg = op_mode != mode_prev_r;
   wire in_rx = op_mode == fsk_rx;
   wire in_tx = op_mode == fsk_tx;
   wire in_synth = (op_mode == fsk_fs) | in_rx | in_tx;
   wire wr_one = link.reg_wr & (link.reg_addr == `FSK_OFS_FLAGS_ONE);
   wire wr_two = link.reg_wr & (link.reg_addr == `FSK_OFS_FLAGS_TWO);
   wire wr_low = link.reg_wr & (link.reg_addr == `FSK_OFS_ROUTE_LOW);
   wire wr_high = link.reg_wr & (link.reg_addr == `FSK_OFS_ROUTE_HIGH);
   wire [7:0] clr_one = wr_one ? link.reg_wdata : 8'h00;
   wire [7:0] clr_two = wr_two ? link.reg_wdata : 8'h00;
   wire flush = clr_two[`FSK_B2_OVF];
   wire q_full = count_r == DEPTH;
   wire q_vacant = count_r == '0;
   wire overrun = fifo_push & q_full & (op_mode != fsk_sleep);
   wire do_push = fifo_push & ~q_full;
   wire do_pop = fifo_pop & ~q_vacant;
   wire emptied = ~q_vacant & (count_nxt == '0);
   wire vacant_nxt = count_nxt == '0;

   // A flush beats any push or pop in the same cycle.
   assign count_nxt = flush ? '0 : count_r + `FSK_CNT_W'(do_push) - `FSK_CNT_W'(do_pop);

   wire settle_hit = (op_mode == fsk_sleep) | ((op_mode == fsk_standby) & osc_running) |
      ((op_mode == fsk_fs) & synth_lock_in) | (in_rx & rssi_sampling) |
      (in_tx & pa_ramp_done);
   wire recv_hit = in_rx & last_byte_evt & (~crc_on | check_fail_keep | crc_ok_evt);
   wire sync_clear = emptied | (clr_one[`FSK_B1_SYNC] & (data_mode == fsk_continuous));

   ////////////////////////////////////////////////////////////////////////////////
   // Next flag values; a setting event beats a write-one or queue-empty clear in the same cycle, but a mode change or leaving the mode wins.
   assign flags_one_nxt[`FSK_B1_SETTLED] = ~mode_chg & (flags_one_r[`FSK_B1_SETTLED] |
      settle_hit);
   assign flags_one_nxt[`FSK_B1_RX] = in_rx & (flags_one_r[`FSK_B1_RX] | rx_chain_done);
   assign flags_one_nxt[`FSK_B1_TX] = in_tx & (flags_one_r[`FSK_B1_TX] | pa_ramp_done);
   assign flags_one_nxt[`FSK_B1_LOCK] = in_synth & synth_lock_in;
   assign flags_one_nxt[`FSK_B1_RSSI] = in_rx & ((flags_one_r[`FSK_B1_RSSI] &
      ~clr_one[`FSK_B1_RSSI]) | (signal_strength_value > signal_strength_limit));
   assign flags_one_nxt[`FSK_B1_TIMEOUT] = in_rx & ((flags_one_r[`FSK_B1_TIMEOUT] &
      ~emptied) | timeout_evt);
   assign flags_one_nxt[`FSK_B1_PRE] = (flags_one_r[`FSK_B1_PRE] & ~clr_one[`FSK_B1_PRE]) |
      preamble_evt;
   assign flags_one_nxt[`FSK_B1_SYNC] = in_rx & ((flags_one_r[`FSK_B1_SYNC] & ~sync_clear) |
      sync_evt);
   assign flags_two_nxt[`FSK_B2_OVF] = (flags_two_r[`FSK_B2_OVF] & ~flush) | overrun;
   assign flags_two_nxt[`FSK_B2_SENT] = in_tx & (flags_two_r[`FSK_B2_SENT] |
      packet_done_evt);
   assign flags_two_nxt[`FSK_B2_RECV] = recv_hit | (flags_two_r[`FSK_B2_RECV] &
      ~vacant_nxt);
   assign flags_two_nxt[`FSK_B2_CRC] = (in_rx & crc_ok_evt) | (flags_two_r[`FSK_B2_CRC] &
      ~vacant_nxt);
   assign flags_two_nxt[`FSK_B2_LOW] = (flags_two_r[`FSK_B2_LOW] & ~clr_two[`FSK_B2_LOW]) |
      supply_sync_r;

   // Queue fill flags are decoded from the live count.
   wire [7:0] flags_two_view = {q_full, q_vacant, count_r > queue_threshold, flags_two_r};

   ////////////////////////////////////////////////////////////////////////////////
   // Register read path.
   wire [7:0] rd_mux = (link.reg_addr == `FSK_OFS_FLAGS_ONE) ? flags_one_r :
      (link.reg_addr == `FSK_OFS_FLAGS_TWO) ? flags_two_view :
      (link.reg_addr == `FSK_OFS_ROUTE_LOW) ? route_low_r :
      (link.reg_addr == `FSK_OFS_ROUTE_HIGH) ? route_high_r : 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Event pin routing.
   wire [11:0] sel_all = {route_low_r, route_high_r[7:4]};
   wire [7:0] one_routed = {flags_one_r[7:4], route_high_r[`FSK_ROUTE_HIGH_PRE] ?
      flags_one_r[`FSK_B1_PRE] : flags_one_r[`FSK_B1_RSSI], flags_one_r[2:0]};
   wire [16:0] src_vec = {1'b0, one_routed, flags_two_view};

   always_comb begin
      for (int i = 0; i < 6; i++) begin
         pin_nxt[i] = src_vec[pin_src(3'(i), sel_all[11 - 2 * i -: 2], data_mode)];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Supply comparator is analog and asynchronous, so it is synchronised first.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         supply_meta_r <= 1'b0;
         supply_sync_r <= 1'b0;
      end else begin
         supply_meta_r <= supply_below;
         supply_sync_r <= supply_meta_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_prev_r <= fsk_sleep;
         flags_one_r <= 8'h00;
         flags_two_r <= 5'h00;
         count_r <= '0;
      end else begin
         mode_prev_r <= op_mode;
         flags_one_r <= flags_one_nxt;
         flags_two_r <= flags_two_nxt;
         count_r <= count_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_low_r <= `FSK_ROUTE_RESET;
         route_high_r <= `FSK_ROUTE_RESET;
      end else begin
         if (wr_low) begin
            route_low_r <= link.reg_wdata;
         end
         if (wr_high) begin
            route_high_r <= link.reg_wdata;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_r <= 8'h00;
         ack_r <= 1'b0;
         flush_r <= 1'b0;
         pin_r <= 6'h00;
      end else begin
         if (link.reg_rd) begin
            rdata_r <= rd_mux;
         end
         ack_r <= link.reg_wr | link.reg_rd;
         flush_r <= flush;
         pin_r <= pin_nxt;
      end
   end

   assign link.reg_rdata = rdata_r;
   assign link.reg_ack = ack_r;
   assign link.event_pin = pin_r;
   assign fifo_flush = flush_r;
   assign fifo_count = count_r;
endmodule
`default_nettype wire

// [src/fsk_irq_host.sv]
// Host end: an APB slave that turns software commands into register link accesses.
// Assumes the device answers every access with a one-cycle acknowledge.
`timescale 1ns/10ps
`default_nettype none
`include "fsk_irq_defines.svh"
module fsk_irq_host
   import fsk_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   fsk_if.host link
);
   logic busy_r;
   logic [6:0] addr_r;
   logic [7:0] wdata_r;
   logic wr_r, rd_r;
   logic [7:0] rdback_r;
   logic [5:0] pin_meta_r, pin_sync_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode; the slave never inserts wait states.
   wire access = psel & penable;
   wire hit_cmd = paddr == `FSK_APB_CMD;
   wire hit_status = paddr == `FSK_APB_STATUS;
   wire hit_pins = paddr == `FSK_APB_PINS;
   wire mapped = hit_cmd | hit_status | hit_pins;
   // A command written while busy is dropped; software polls busy first.
   wire start = access & pwrite & hit_cmd & ~busy_r;
   wire [6:0] cmd_addr = pwdata[6:0];
   // Reserved bits of the high route register are kept at their zero default.
   wire [7:0] cmd_data = (cmd_addr == `FSK_OFS_ROUTE_HIGH) ?
      (pwdata[15:8] & ~`FSK_ROUTE_HIGH_RSVD) : pwdata[15:8];

   assign pready = 1'b1;
   assign pslverr = access & ~mapped;
   assign prdata = hit_status ? {16'h0000, rdback_r, 7'h00, busy_r} :
      hit_pins ? {26'h0000000, pin_sync_r} : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////////////
   // Link sequencer: one strobe per command, busy until the acknowledge.
   // Flag clears are sent as ordinary writes with ones in the bits.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_r <= 1'b0;
         addr_r <= 7'h00;
         wdata_r <= 8'h00;
         wr_r <= 1'b0;
         rd_r <= 1'b0;
         rdback_r <= 8'h00;
      end else begin
         wr_r <= start & pwdata[`FSK_CMD_WRITE];
         rd_r <= start & ~pwdata[`FSK_CMD_WRITE];
         if (start) begin
            busy_r <= 1'b1;
            addr_r <= cmd_addr;
            wdata_r <= cmd_data;
         end else if (link.reg_ack) begin
            busy_r <= 1'b0;
            rdback_r <= link.reg_rdata;
         end
      end
   end

   // Event pins are treated as external pins and synchronised.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_r <= 6'h00;
         pin_sync_r <= 6'h00;
      end else begin
         pin_meta_r <= link.event_pin;
         pin_sync_r <= pin_meta_r;
      end
   end

   assign link.reg_addr = addr_r;
   assign link.reg_wdata = wdata_r;
   assign link.reg_wr = wr_r;
   assign link.reg_rd = rd_r;
endmodule
`default_nettype wire

// [tb/fsk_irq_checker.sv]
// Concurrent checks on the register link between the host end and the device end.
// Assumes instantiation beside the link interface, on pclk with presetn.
`timescale 1ns/10ps
`default_nettype none
`include "fsk_irq_defines.svh"
module fsk_irq_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic [5:0] event_pin
);
   logic [7:0] low_r;
   logic [7:0] high_r;
   wire logic mapped = reg_addr >= `FSK_OFS_FLAGS_ONE && reg_addr <= `FSK_OFS_ROUTE_HIGH;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Shadow copies of the route registers, so that read data can be predicted.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_r <= `FSK_ROUTE_RESET;
         high_r <= `FSK_ROUTE_RESET;
      end else if (reg_wr) begin
         if (reg_addr == `FSK_OFS_ROUTE_LOW) low_r <= reg_wdata;
         if (reg_addr == `FSK_OFS_ROUTE_HIGH) high_r <= reg_wdata;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_strobe;
      reg_wr || reg_rd;
   endsequence
   sequence s_read_two;
      reg_rd && reg_addr == `FSK_OFS_FLAGS_TWO ##1 reg_ack;
   endsequence
   a_ack_follows: assert property (s_strobe |=> reg_ack)
      else $error("link acknowledge missing after a strobe");
   a_ack_cause: assert property (reg_ack |-> $past(reg_wr || reg_rd))
      else $error("link acknowledge without a strobe");
   a_ack_single: assert property (reg_ack && !(reg_wr || reg_rd) |=> !reg_ack)
      else $error("link acknowledge longer than one cycle");
   a_route_low: assert property (reg_rd && reg_addr == `FSK_OFS_ROUTE_LOW |=> reg_rdata == low_r)
      else $error("low route register read back wrong");
   a_route_high: assert property (reg_rd && reg_addr == `FSK_OFS_ROUTE_HIGH |=> reg_rdata == high_r)
      else $error("high route register read back wrong");
   a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
      else $error("unmapped read returned nonzero data");
   a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   a_full_vacant: assert property (s_read_two |-> !(reg_rdata[7] && reg_rdata[6]))
      else $error("queue full and vacant both set");
   a_level_vacant: assert property (s_read_two |-> !(reg_rdata[5] && reg_rdata[6]))
      else $error("queue level and vacant both set");
   cover property (event_pin != 6'h00);
endmodule
`default_nettype wire

// [tb/test_fsk_irq_flags_pin_map.sv]
// Bench for the flag and pin routing block: APB host end joined to the device end.
// Assumes the host reports link completion through its busy bit.
`timescale 1ns/10ps
`default_nettype none
`include "fsk_irq_defines.svh"
module test_fsk_irq_flags_pin_map
   import fsk_pkg::*;
;
   localparam logic [6:0] f1 = `FSK_OFS_FLAGS_ONE, f2 = `FSK_OFS_FLAGS_TWO;
   localparam logic [6:0] rl = `FSK_OFS_ROUTE_LOW, rh = `FSK_OFS_ROUTE_HIGH;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lock, sup, errv;
   logic osc, rsamp, crcon, keep, fl;
   logic [6:0] cnt;
   logic [7:0] paddr, ssv, ssl;
   logic [31:0] pwdata, prdata, rdv, v;
   logic [31:0] seed = 32'h0000_81AB;
   logic [9:0] ev;
   logic [6:0] thr;
   fsk_op_type op_mode;
   fsk_data_type data_mode;
   int n_fail = 0;
   int checks = 0;
   int t;
   int n_flush = 0;
   fsk_if i_fsk_if ();
   fsk_irq_dev i_fsk_irq_dev (.pclk, .presetn, .link(i_fsk_if), .op_mode, .data_mode,
      .osc_running(osc), .synth_lock_in(lock), .rssi_sampling(rsamp), .rx_chain_done(ev[8]),
      .pa_ramp_done(ev[9]), .signal_strength_value(ssv), .signal_strength_limit(ssl),
      .timeout_evt(ev[0]), .preamble_evt(ev[1]), .sync_evt(ev[2]), .fifo_push(ev[3]),
      .fifo_pop(ev[4]), .queue_threshold(thr), .packet_done_evt(ev[5]),
      .last_byte_evt(ev[6]), .crc_ok_evt(ev[7]), .crc_on(crcon), .check_fail_keep(keep),
      .supply_below(sup), .fifo_flush(fl), .fifo_count(cnt));
   fsk_irq_host i_fsk_irq_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .link(i_fsk_if));
   fsk_irq_checker i_fsk_irq_checker (.pclk, .presetn, .reg_addr(i_fsk_if.reg_addr),
      .reg_wdata(i_fsk_if.reg_wdata), .reg_wr(i_fsk_if.reg_wr), .reg_rd(i_fsk_if.reg_rd),
      .reg_rdata(i_fsk_if.reg_rdata), .reg_ack(i_fsk_if.reg_ack),
      .event_pin(i_fsk_if.event_pin));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xorshift();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [7:0] fifo_exp(input int n, input int th);
      return {n == `FSK_FIFO_DEPTH, n == 0, n > th, 5'h00};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      {rdv, errv} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask
   // The host serves one link access at a time, so every command waits for busy to drop.
   task automatic dreg(input logic w, input logic [6:0] a, input logic [7:0] d);
      apb(1'b1, `FSK_APB_CMD, {15'h0000, w, d, 1'b0, a});
      do apb(1'b0, `FSK_APB_STATUS, 32'h0000_0000); while (rdv[0] !== 1'b0);
   endtask
   task automatic rdchk(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
      dreg(1'b0, a, 8'h00);
      chk(rdv[15:8] & m, e);
   endtask
   task automatic pulse(input int b, input int n);
      repeat (n) begin
         @(posedge pclk);
         ev[b] <= 1'b1;
         @(posedge pclk);
         ev[b] <= 1'b0;
      end
   endtask
   task automatic test_done();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Every queue flush pulse is counted, so that exactly one per overflow clear is seen.
   always @(posedge pclk) begin
      if (fl === 1'b1) begin
         n_flush <= n_flush + 1;
      end
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      $display("[ERR] %0t watchdog expired", $time);
      test_done();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {ev, ssv, ssl, thr, lock, sup} = '0;
      {osc, rsamp, crcon, keep} = '0;
      op_mode = fsk_sleep;
      data_mode = fsk_packet;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(rl, 8'hFF, 8'h00);
      rdchk(rh, 8'hFF, 8'h00);
      rdchk(7'h42, 8'hFF, 8'h00);
      rdchk(f1, 8'h80, 8'h80);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk({7'h00, errv}, 8'h01);
      for (int i = 0; i < 4; i++) begin
         v = xorshift();
         dreg(1'b1, rl, v[7:0]);
         rdchk(rl, 8'hFF, v[7:0]);
         dreg(1'b1, rh, v[15:8]);
         rdchk(rh, 8'hFF, v[15:8] & 8'hF1);
      end
      op_mode <= fsk_tx;
      lock <= 1'b1;
      pulse(9, 1);
      rdchk(f1, 8'hB0, 8'hB0);
      pulse(5, 1);
      rdchk(f2, 8'h08, 8'h08);
      op_mode <= fsk_standby;
      rdchk(f1, 8'hA0, 8'h00);
      rdchk(f2, 8'h08, 8'h00);
      osc <= 1'b1;
      rdchk(f1, 8'h80, 8'h80);
      op_mode <= fsk_rx;
      lock <= 1'b0;
      rdchk(f1, 8'h90, 8'h00);
      lock <= 1'b1;
      rsamp <= 1'b1;
      v = xorshift();
      {ssl, ssv} <= {1'b0, v[6:0], 1'b0, v[6:0]};
      pulse(8, 1);
      rdchk(f1, 8'hD8, 8'hD0);
      ssv <= {1'b0, v[6:0]} + 8'h01;
      rdchk(f1, 8'h08, 8'h08);
      ssv <= 8'h00;
      dreg(1'b1, f1, 8'h08);
      rdchk(f1, 8'h08, 8'h00);
      pulse(1, 1);
      pulse(2, 1);
      pulse(0, 1);
      rdchk(f1, 8'h07, 8'h07);
      dreg(1'b1, f1, 8'h07);
      rdchk(f1, 8'h07, 8'h05);
      pulse(1, 1);
      dreg(1'b1, rh, 8'hC0);
      chk({7'h00, i_fsk_if.event_pin[4]}, 8'h00);
      dreg(1'b1, rh, 8'hC1);
      chk({7'h00, i_fsk_if.event_pin[4]}, 8'h01);
      apb(1'b0, `FSK_APB_PINS, 32'h0000_0000);
      chk({7'h00, rdv[4]}, 8'h01);
      t = xorshift() % 60;
      thr <= t[6:0];
      pulse(3, t);
      rdchk(f2, 8'hE0, fifo_exp(t, t));
      chk({1'b0, cnt}, t[7:0]);
      pulse(3, 1);
      rdchk(f2, 8'hE0, fifo_exp(t + 1, t));
      pulse(3, 65 - t);
      rdchk(f2, 8'hF0, fifo_exp(66, t));
      pulse(3, 1);
      rdchk(f2, 8'hF0, fifo_exp(66, t) | 8'h10);
      pulse(0, 1);
      dreg(1'b1, f2, 8'h10);
      rdchk(f2, 8'hF0, fifo_exp(0, t));
      chk({1'b0, cnt}, 8'h00);
      chk(n_flush[7:0], 8'h01);
      rdchk(f1, 8'h05, 8'h00);
      pulse(3, 1);
      pulse(6, 1);
      pulse(7, 1);
      rdchk(f2, 8'h06, 8'h06);
      pulse(4, 1);
      rdchk(f2, 8'h46, 8'h40);
      // With the check enabled and no pass, the last byte alone must not raise the frame flag.
      {crcon, keep} <= 2'b10;
      pulse(3, 1);
      pulse(6, 1);
      rdchk(f2, 8'h06, 8'h00);
      keep <= 1'b1;
      pulse(6, 1);
      rdchk(f2, 8'h06, 8'h04);
      pulse(4, 1);
      data_mode <= fsk_continuous;
      dreg(1'b1, rl, 8'h00);
      pulse(2, 1);
      repeat (3) @(posedge pclk);
      chk({7'h00, i_fsk_if.event_pin[0]}, 8'h01);
      dreg(1'b1, f1, 8'h01);
      rdchk(f1, 8'h01, 8'h00);
      chk({7'h00, i_fsk_if.event_pin[0]}, 8'h00);
      data_mode <= fsk_long_range;
      ssv <= 8'hFF;
      pulse(2, 1);
      repeat (3) @(posedge pclk);
      chk({2'b00, i_fsk_if.event_pin}, 8'h00);
      apb(1'b0, `FSK_APB_PINS, 32'h0000_0000);
      chk(rdv[7:0], 8'h00);
      rdchk(f1, 8'h08, 8'h08);
      op_mode <= fsk_standby;
      rdchk(f1, 8'h4F, 8'h02);
      sup <= 1'b1;
      repeat (4) @(posedge pclk);
      sup <= 1'b0;
      rdchk(f2, 8'h01, 8'h01);
      dreg(1'b1, f2, 8'h01);
      rdchk(f2, 8'h01, 8'h00);
      test_done();
   end
endmodule
`default_nettype wire
